// ---- hw/ots_pkg.sv ----
// package: constants, register map and state codes for the trigger sequencer
package ots_pkg;
  // register byte offsets
  localparam logic [5:0] OFS_CTRL      = 6'h00;
  localparam logic [5:0] OFS_CMD       = 6'h04;
  localparam logic [5:0] OFS_STATUS    = 6'h08;
  localparam logic [5:0] OFS_DELAY     = 6'h0C;
  localparam logic [5:0] OFS_VTRIG     = 6'h10;
  localparam logic [5:0] OFS_ITRIG     = 6'h14;
  localparam logic [5:0] OFS_VOUT      = 6'h18;
  localparam logic [5:0] OFS_IOUT      = 6'h1C;
  localparam logic [5:0] OFS_LISTCFG   = 6'h20;
  localparam logic [5:0] OFS_LISTWR    = 6'h24;
  localparam logic [5:0] OFS_DWELLWR   = 6'h28;
  // control bit positions
  localparam int CTRL_AUTO_REARM = 0;
  localparam int CTRL_VLIST      = 1;
  localparam int CTRL_ILIST      = 2;
  localparam int CTRL_STEP_AUTO  = 3;
  localparam int CTRL_SRC_LO     = 4;
  // command bit positions
  localparam int CMD_ABORT   = 0;
  localparam int CMD_ARM     = 1;
  localparam int CMD_IMMED   = 2;
  localparam int CMD_RECALL  = 3;
  localparam int CMD_RESET   = 4;
  // status bit positions
  localparam int ST_HOLD     = 0;
  localparam int ST_AWAIT    = 1;
  localparam int ST_VPEND    = 2;
  localparam int ST_IPEND    = 3;
  localparam int ST_STATE_LO = 8;
  // sizes and resets
  localparam int LIST_DEPTH = 20;
  localparam int PTR_W      = 5;
  localparam int LVL_W      = 16;
  localparam int TIME_W     = 32;
  localparam int CNT_W      = 16;
  localparam logic [CNT_W-1:0] LIST_COUNT_RST = 16'h0001;
  localparam logic [PTR_W-1:0] LIST_LEN_RST   = 5'h01;
  localparam logic [31:0]      UNMAPPED_DATA  = 32'h0000_0000;

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_ARMED = 5'b00010,
    S_DELAY = 5'b00100,
    S_OCHG  = 5'b01000,
    S_DWELL = 5'b10000
  } ots_state_t;
endpackage : ots_pkg

// ---- hw/ots_sequencer.sv ----
// trigger sequencer with avalon-mm register slave
//
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
module ots_sequencer
  import ots_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // avalon-mm slave
  input  wire logic [5:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // trigger sources, one per source index
  input  wire logic [3:0]        trigSources,
  // output levels
  output logic      [LVL_W-1:0]  voltOut,
  output logic      [LVL_W-1:0]  currOut,
  // status flags and event pulses
  output logic                   holdPhaseFlag,
  output logic                   awaitingTriggerFlag,
  output logic                   listDonePulse,
  output logic                   triggerReceivedPulse,
  output logic                   delayDonePulse,
  output logic                   stepEndPulse,
  output logic                   stepBeginPulse
);

  // merge byte lanes of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  ots_state_t           state_r;
  ots_state_t           state_nxt;
  logic [7:0]           ctrl_r;
  logic [TIME_W-1:0]    delay_r;
  logic [LVL_W-1:0]     vPend_r;
  logic [LVL_W-1:0]     iPend_r;
  logic                 vPendOk_r;
  logic                 iPendOk_r;
  logic [PTR_W-1:0]     listLen_r;
  logic [CNT_W-1:0]     listCount_r;
  logic [PTR_W-1:0]     wrIdx_r;
  logic [LVL_W-1:0]     vList_r [LIST_DEPTH];
  logic [LVL_W-1:0]     iList_r [LIST_DEPTH];
  logic [TIME_W-1:0]    dwList_r [LIST_DEPTH];
  logic [PTR_W-1:0]     ptr_r;
  logic [CNT_W-1:0]     pass_r;
  logic [TIME_W-1:0]    timer_r;
  logic                 lastPoint_r;
  logic                 listDone_r;
  logic                 rdPending_r;

  logic wrEn;
  logic cmdWr;
  logic abortCmd;
  logic armCmd;
  logic immCmd;
  logic listMode;
  logic srcEvent;
  logic timerDone;

  // bus answer: one wait cycle for reads, writes taken at once
  assign waitrequest = read & ~rdPending_r;
  assign wrEn        = write;
  assign cmdWr       = wrEn & (address == OFS_CMD);
  // list point, dwell and list config writes imply an abort as well
  assign abortCmd    = cmdWr & (writedata[CMD_ABORT] | writedata[CMD_RECALL]
                       | writedata[CMD_RESET])
                     | wrEn & (address == OFS_LISTCFG || address == OFS_LISTWR
                       || address == OFS_DWELLWR);
  assign armCmd      = cmdWr & writedata[CMD_ARM];
  assign immCmd      = cmdWr & writedata[CMD_IMMED];
  assign listMode    = ctrl_r[CTRL_VLIST] | ctrl_r[CTRL_ILIST];
  assign srcEvent    = trigSources[ctrl_r[CTRL_SRC_LO +: 2]];
  assign timerDone   = (timer_r == '0);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdPending_r <= 1'b0;
    end else begin
      rdPending_r <= read & ~rdPending_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      readdata <= 32'h0000_0000;
    end else if (read & ~rdPending_r) begin
      case (address)
        OFS_CTRL:    readdata <= {24'h00_0000, ctrl_r};
        OFS_STATUS:  readdata <= {19'h0_0000, state_r, 4'h0, iPendOk_r, vPendOk_r,
                                  awaitingTriggerFlag, holdPhaseFlag};
        OFS_DELAY:   readdata <= delay_r;
        OFS_VTRIG:   readdata <= {16'h0000, vPend_r};
        OFS_ITRIG:   readdata <= {16'h0000, iPend_r};
        OFS_VOUT:    readdata <= {16'h0000, voltOut};
        OFS_IOUT:    readdata <= {16'h0000, currOut};
        OFS_LISTCFG: readdata <= {listCount_r, 3'h0, wrIdx_r, 3'h0, listLen_r};
        default:     readdata <= UNMAPPED_DATA;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_r      <= 8'h00;
      delay_r     <= 32'h0000_0000;
      listLen_r   <= LIST_LEN_RST;
      listCount_r <= LIST_COUNT_RST;
    end else if (wrEn) begin
      case (address)
        OFS_CTRL:    ctrl_r  <= 8'(merge({24'h00_0000, ctrl_r}, writedata, byteenable));
        OFS_DELAY:   delay_r <= merge(delay_r, writedata, byteenable);
        OFS_LISTCFG: begin
          if (writedata[PTR_W-1:0] != '0 && writedata[PTR_W-1:0] <= PTR_W'(LIST_DEPTH)) begin
            listLen_r <= writedata[PTR_W-1:0];
          end
          listCount_r <= writedata[31:16];
        end
        default: ;
      endcase
    end
  end

  // list storage; each write fills the point at wrIdx, and a dwell write then advances it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wrIdx_r <= '0;
    end else if (wrEn && address == OFS_LISTCFG) begin
      wrIdx_r <= writedata[8 +: PTR_W];
    end else if (wrEn && address == OFS_LISTWR) begin
      if (wrIdx_r < PTR_W'(LIST_DEPTH)) begin
        vList_r[wrIdx_r] <= writedata[LVL_W-1:0];
        iList_r[wrIdx_r] <= writedata[31:16];
      end
    end else if (wrEn && address == OFS_DWELLWR) begin
      if (wrIdx_r < PTR_W'(LIST_DEPTH)) begin
        dwList_r[wrIdx_r] <= writedata;
      end
      wrIdx_r <= wrIdx_r + 5'h01;
    end
  end

  // state transitions
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (armCmd | ctrl_r[CTRL_AUTO_REARM]) begin
          state_nxt = S_ARMED; // triggers ignored here
        end
      end
      S_ARMED: begin
        if (immCmd) begin
          state_nxt = S_OCHG;
        end else if (srcEvent) begin
          state_nxt = S_DELAY;
        end
      end
      S_DELAY: begin
        if (immCmd | timerDone) begin
          state_nxt = S_OCHG;
        end
      end
      S_OCHG: begin
        if (listMode) begin
          state_nxt = S_DWELL;
        end else begin
          state_nxt = ctrl_r[CTRL_AUTO_REARM] ? S_ARMED : S_IDLE;
        end
      end
      S_DWELL: begin
        if (timerDone) begin
          if (!listDone_r && ctrl_r[CTRL_STEP_AUTO]) begin
            state_nxt = S_OCHG;
          end else begin
            state_nxt = ctrl_r[CTRL_AUTO_REARM] ? S_ARMED : S_IDLE;
          end
        end
      end
      default: state_nxt = S_IDLE;
    endcase
    if (abortCmd) begin
      state_nxt = S_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // delay and dwell timer, counts down once per cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      timer_r <= '0;
    end else if (state_r == S_ARMED && state_nxt == S_DELAY) begin
      timer_r <= delay_r;
    end else if (state_r == S_OCHG && listMode) begin
      // fixed mode must not pull unwritten dwell slots into the timer
      timer_r <= dwList_r[ptr_r];
    end else if (!timerDone) begin
      timer_r <= timer_r - 32'h0000_0001;
    end
  end

  // pending triggered levels; a write in the apply cycle still wins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      vPend_r   <= '0;
      iPend_r   <= '0;
      vPendOk_r <= 1'b0;
      iPendOk_r <= 1'b0;
    end else begin
      if (state_r == S_OCHG && !listMode) begin
        vPendOk_r <= 1'b0;
        iPendOk_r <= 1'b0;
      end
      if (wrEn && address == OFS_VTRIG) begin
        vPend_r   <= writedata[LVL_W-1:0];
        vPendOk_r <= 1'b1;
      end
      if (wrEn && address == OFS_ITRIG) begin
        iPend_r   <= writedata[LVL_W-1:0];
        iPendOk_r <= 1'b1;
      end
    end
  end

  // output levels; direct writes outside S_OCHG override until next change
  always_ff @(posedge clk) begin
    if (!nrst) begin
      voltOut <= '0;
      currOut <= '0;
    end else if (state_r == S_OCHG) begin
      if (listMode) begin
        if (ctrl_r[CTRL_VLIST]) begin
          voltOut <= vList_r[ptr_r];
        end
        if (ctrl_r[CTRL_ILIST]) begin
          currOut <= iList_r[ptr_r];
        end
      end else begin
        if (vPendOk_r) begin
          voltOut <= vPend_r;
        end
        if (iPendOk_r) begin
          currOut <= iPend_r;
        end
      end
    end else begin
      if (wrEn && address == OFS_VOUT) begin
        voltOut <= writedata[LVL_W-1:0];
      end
      if (wrEn && address == OFS_IOUT) begin
        currOut <= writedata[LVL_W-1:0];
      end
    end
  end

  // list pointer and pass counting; a zero count means repeat forever
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ptr_r       <= '0;
      pass_r      <= '0;
      lastPoint_r <= 1'b0;
      listDone_r  <= 1'b0;
    end else if (abortCmd) begin
      ptr_r       <= '0;
      pass_r      <= '0;
      lastPoint_r <= 1'b0;
      listDone_r  <= 1'b0;
    end else if (state_r == S_OCHG && listMode) begin
      lastPoint_r <= (ptr_r == listLen_r - 5'h01);
      listDone_r  <= 1'b0;
      if (ptr_r == listLen_r - 5'h01) begin
        ptr_r  <= '0;
        pass_r <= pass_r + 16'h0001;
        if (listCount_r != '0 && pass_r + 16'h0001 >= listCount_r) begin
          listDone_r <= 1'b1;
          pass_r     <= '0;
        end
      end else begin
        ptr_r <= ptr_r + 5'h01;
      end
    end
  end

  // status flags
  assign holdPhaseFlag       = (state_r == S_DWELL);
  assign awaitingTriggerFlag = (state_r == S_ARMED) | (state_r == S_DELAY);

  // event pulses, one cycle on the transition edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      listDonePulse        <= 1'b0;
      triggerReceivedPulse <= 1'b0;
      delayDonePulse       <= 1'b0;
      stepEndPulse         <= 1'b0;
      stepBeginPulse       <= 1'b0;
    end else begin
      listDonePulse        <= state_r == S_DWELL && state_nxt != S_DWELL
                              && lastPoint_r;
      triggerReceivedPulse <= state_r == S_ARMED && state_nxt != S_ARMED;
      delayDonePulse       <= state_r == S_DELAY && state_nxt != S_DELAY;
      stepEndPulse         <= state_r == S_DWELL && state_nxt != S_DWELL;
      stepBeginPulse       <= state_r != S_DWELL && state_nxt == S_DWELL;
    end
  end

endmodule : ots_sequencer

// ---- bench/ots_sequencer_asserts.sv ----
// checker: flag and event pulse relations of the trigger sequencer
`timescale 1ns/10ps
module ots_sequencer_asserts
  import ots_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // register bus
  input wire logic [5:0]  address,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic        waitrequest,
  // flags and pulses
  input wire logic        holdPhaseFlag,
  input wire logic        awaitingTriggerFlag,
  input wire logic        listDonePulse,
  input wire logic        triggerReceivedPulse,
  input wire logic        delayDonePulse,
  input wire logic        stepEndPulse,
  input wire logic        stepBeginPulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence dwellIn;
    !holdPhaseFlag ##1 holdPhaseFlag;
  endsequence
  sequence dwellOut;
    holdPhaseFlag ##1 !holdPhaseFlag;
  endsequence
  sequence awaitOut;
    awaitingTriggerFlag ##1 !awaitingTriggerFlag;
  endsequence
  sequence abortWr;
    write && !waitrequest && address == OFS_CMD && writedata[CMD_ABORT];
  endsequence
  a_reset_idle: assert property ($rose(nrst) |-> !holdPhaseFlag && !awaitingTriggerFlag)
    else $error("flags set after reset");
  a_abort_to_idle: assert property (abortWr |=> !holdPhaseFlag && !awaitingTriggerFlag)
    else $error("abort did not reach idle");
  a_step_begin_dwell: assert property (dwellIn |-> stepBeginPulse)
    else $error("no step begin pulse on dwell entry");
  a_step_end_dwell: assert property (dwellOut |-> stepEndPulse)
    else $error("no step end pulse on dwell exit");
  a_list_done_exit: assert property (listDonePulse |-> stepEndPulse && !holdPhaseFlag)
    else $error("list done outside dwell exit");
  a_flags_exclusive: assert property (!(holdPhaseFlag && awaitingTriggerFlag))
    else $error("hold and awaiting flags together");
  a_await_leave: assert property (awaitOut |-> triggerReceivedPulse || delayDonePulse)
    else $error("leaving armed or delay without pulse");
  a_delay_done_out: assert property (delayDonePulse |-> !awaitingTriggerFlag)
    else $error("delay done while still waiting");
  a_dwell_no_trig: assert property (holdPhaseFlag |-> !triggerReceivedPulse)
    else $error("trigger taken while dwelling");
  a_pulse_single: assert property (triggerReceivedPulse |=> !triggerReceivedPulse)
    else $error("trigger pulse longer than one cycle");
  a_begin_single: assert property (stepBeginPulse |=> !stepBeginPulse)
    else $error("step begin pulse longer than one cycle");
  a_done_single: assert property (listDonePulse |=> !listDonePulse)
    else $error("list done pulse longer than one cycle");
endmodule : ots_sequencer_asserts

bind ots_sequencer ots_sequencer_asserts ots_sequencer_asserts_inst (.clk, .nrst, .address,
  .write, .writedata, .waitrequest, .holdPhaseFlag, .awaitingTriggerFlag, .listDonePulse,
  .triggerReceivedPulse, .delayDonePulse, .stepEndPulse, .stepBeginPulse);

// ---- bench/ots_trig_host.sv ----
// partner: host-side trigger line driver
`timescale 1ns/10ps
module ots_trig_host (
  // clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // requests from the bench
  input wire logic [1:0] sel,
  input wire logic       fire,
  input wire logic       noise,
  // trigger lines
  output logic     [3:0] trigSources
);
  // noise hits only lines not selected, so a loose source decode shows up
  always_ff @(posedge clk) begin
    if (!nrst)
      trigSources <= 4'h0;
    else if (fire)
      trigSources <= 4'h1 << sel;
    else if (noise)
      trigSources <= ~(4'h1 << sel);
    else
      trigSources <= 4'h0;
  end
endmodule : ots_trig_host

// ---- bench/tb_ots_sequencer.sv ----
// testbench: register-driven scenarios against a list and level model
`timescale 1ns/10ps
module tb_ots_sequencer
  import ots_pkg::*;
;
  logic             clk = 0, nrst = 0, read = 0, write = 0, fire = 0, noise = 0;
  logic [5:0]       address = 6'h00;
  logic [31:0]      writedata = 32'h0, rd, readdata, p;
  logic [3:0]       byteenable = 4'hF, trigSources;
  logic [1:0]       src = 2'h0;
  logic [15:0]      v, i;
  logic             waitrequest, holdPhaseFlag, awaitingTriggerFlag, listDonePulse;
  logic             triggerReceivedPulse, delayDonePulse, stepEndPulse, stepBeginPulse;
  logic [LVL_W-1:0] voltOut, currOut;
  int               miscompares = 0, n_checks = 0, cyc = 0, nBeg = 0, nLd = 0, nTr = 0;
  logic [31:0]      pts[$];

  ots_sequencer ots_sequencer_inst (.clk, .nrst, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .trigSources, .voltOut, .currOut, .holdPhaseFlag,
    .awaitingTriggerFlag, .listDonePulse, .triggerReceivedPulse, .delayDonePulse,
    .stepEndPulse, .stepBeginPulse);
  ots_trig_host ots_trig_host_inst (.clk, .nrst, .sel(src), .fire, .noise, .trigSources);

  always #10 clk = ~clk;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // model side: list points checked at each step start
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      miscompares++;
      end_of_test();
    end
    if (stepBeginPulse && pts.size() > 0) begin
      chk(voltOut, pts[nBeg % pts.size()][15:0]);
      chk(currOut, pts[nBeg % pts.size()][31:16]);
      nBeg <= nBeg + 1;
    end
    nLd <= nLd + int'(listDonePulse);
    nTr <= nTr + int'(triggerReceivedPulse);
  end

  // one access, then one idle edge so strobes never toggle twice in a step
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    @(posedge clk);
    while (waitrequest) @(posedge clk);
    write <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rdr(input logic [5:0] a);
    address <= a;
    read <= 1'b1;
    @(posedge clk);
    while (waitrequest) @(posedge clk);
    rd = readdata;
    read <= 1'b0;
    @(posedge clk);
  endtask : rdr

  task automatic cmd(input int b);
    wr(OFS_CMD, 32'h1 << b);
  endtask : cmd

  task automatic st(input ots_state_t s);
    rdr(OFS_STATUS);
    chk(rd[12:8], s);
    chk({rd[ST_HOLD], holdPhaseFlag}, {2{s == S_DWELL}});
    chk(awaitingTriggerFlag, s == S_ARMED || s == S_DELAY);
  endtask : st

  task automatic pulse(input bit n);
    if (n)
      noise <= 1'b1;
    else
      fire <= 1'b1;
    @(posedge clk);
    noise <= 1'b0;
    fire <= 1'b0;
    @(posedge clk);
  endtask : pulse

  initial begin
    void'($urandom(80));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    src <= 2'($urandom);
    @(posedge clk);
    wr(OFS_CTRL, {26'h0, src, 4'h0});
    pulse(0);
    st(S_IDLE);
    chk(nTr, 0);
    rdr(6'h3C);
    chk(rd, UNMAPPED_DATA);
    $display("test idle done");
    v = 16'($urandom);
    i = 16'($urandom);
    wr(OFS_VTRIG, {16'h0, v});
    wr(OFS_ITRIG, {16'h0, i});
    wr(OFS_DELAY, 32'h8);
    cmd(CMD_ARM);
    st(S_ARMED);
    pulse(1);
    st(S_ARMED);
    pulse(0);
    st(S_DELAY);
    repeat (12) @(posedge clk);
    chk({currOut, voltOut}, {i, v});
    st(S_IDLE);
    chk(rd[3:2], 2'b00);
    chk(nTr, 1);
    cmd(CMD_ARM);
    cmd(CMD_IMMED);
    repeat (3) @(posedge clk);
    chk({currOut, voltOut}, {i, v});
    st(S_IDLE);
    $display("test fixed done");
    v = 16'($urandom);
    wr(OFS_VTRIG, {16'h0, v});
    wr(OFS_DELAY, 32'hC8);
    cmd(CMD_ARM);
    pulse(0);
    cmd(CMD_IMMED);
    repeat (3) @(posedge clk);
    st(S_IDLE);
    chk(voltOut, v);
    $display("test delay cancel done");
    wr(OFS_LISTCFG, 32'h0002_0003);
    pts = {};
    nBeg = 0;
    nLd = 0;
    for (int k = 0; k < 3; k++) begin
      p = $urandom;
      pts.push_back(p);
      wr(OFS_LISTWR, p);
      wr(OFS_DWELLWR, 32'(4 + k));
    end
    wr(OFS_CTRL, {26'h0, src, 4'b1110});
    cmd(CMD_ARM);
    cmd(CMD_IMMED);
    repeat (70) @(posedge clk);
    chk(nBeg, 6);
    chk(nLd, 2);
    st(S_IDLE);
    $display("test list auto done");
    wr(OFS_LISTCFG, 32'h0000_0003);
    nBeg = 0;
    wr(OFS_DELAY, 32'h2);
    wr(OFS_CTRL, {26'h0, src, 4'b0111});
    st(S_ARMED);
    pulse(0);
    repeat (20) @(posedge clk);
    st(S_ARMED);
    chk(nBeg, 1);
    cmd(CMD_ABORT);
    st(S_ARMED);
    $display("test rearm done");
    wr(OFS_CTRL, {26'h0, src, 4'b1110});
    wr(OFS_LISTCFG, 32'h0001_0001);
    st(S_IDLE);
    p = $urandom;
    pts = {p};
    nBeg = 0;
    wr(OFS_LISTWR, p);
    wr(OFS_DWELLWR, 32'h12C);
    cmd(CMD_ARM);
    cmd(CMD_IMMED);
    st(S_DWELL);
    pulse(0);
    st(S_DWELL);
    cmd(CMD_ABORT);
    st(S_IDLE);
    foreach (pts[k]) begin
      cmd(CMD_ARM);
      cmd(CMD_RECALL);
      st(S_IDLE);
      cmd(CMD_ARM);
      cmd(CMD_RESET);
      st(S_IDLE);
    end
    $display("test abort done");
    end_of_test();
  end
endmodule : tb_ots_sequencer
